// File: verilog/brownout_sleep_wake_control.sv
// Function
// - Brown-out detection runs only while its enable bit is set.
// - Supply below threshold longer than minimum duration resets; shorter dips ignored.
// - Any reset holds until supply recovers, then power-up timer adds 72 ms.
// - Supply dip during power-up timer returns to reset and restarts full delay.
// - Sleep clears watchdog, clears power-down flag, sets time-out flag, stops oscillator.
// - Ports keep their pre-sleep drive level and enable while asleep.
// - Watchdog reset stays internal and never drives the external reset pin.
// - Wake on reset pin, enabled watchdog time-out, or enabled interrupt sources.
// - Reset pin wake resets the device; watchdog and interrupt wakes resume.
// - Power-down flag set at power-up; time-out flag cleared by watchdog wake.
// - Executing sleep prefetches the instruction at the next program address.
// - Interrupt wakes only with its own enable set, regardless of global enable.
// - Global enable off: continue inline; on: one instruction, then vector 0004h.
// - Enabled pending interrupt at sleep: sleep completes then wakes at once.
// - Watchdog is cleared on every wake from sleep, whatever the source.
// - Crystal modes wait 1024 oscillator cycles on watchdog or interrupt wake; RC mode does not.
// - Power-up timer is skipped while its disable bit is set.
`timescale 1ns/100ps
`include "bsw_params.svh"

module brownout_sleep_wake_control #(
  parameter int unsigned POWERUP_CYCLES = `BSW_POWERUP_MS * 1000 * `BSW_CLK_MHZ,
  parameter int unsigned BROWNOUT_MIN_CYCLES = `BSW_BROWNOUT_MIN_US * `BSW_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply monitor and reset pin
  input wire logic supply_low,
  input wire logic external_reset_pin_n,
  output logic external_reset_pin_o,
  output logic external_reset_pin_oe,
  // Core side
  input wire logic sleep_exec,
  input wire logic [`BSW_PC_W-1:0] pc,
  input wire logic instr_retire,
  input wire logic global_irq_enable,
  input wire logic [`BSW_IRQ_W-1:0] irq_flag,
  input wire logic [`BSW_IRQ_W-1:0] irq_enable,
  input wire logic wdt_timeout,
  output logic wdt_clear,
  output logic core_reset,
  output logic core_run,
  output logic osc_drive_en,
  output logic prefetch_req,
  output logic [`BSW_PC_W-1:0] prefetch_addr,
  output logic wake_pulse,
  output logic vector_branch,
  output logic [`BSW_PC_W-1:0] vector_addr,
  output logic powerdown_flag,
  output logic timeout_flag,
  // Port pads
  input wire logic [`BSW_PORT_W-1:0] port_out,
  input wire logic [`BSW_PORT_W-1:0] port_dir_oe,
  output logic [`BSW_PORT_W-1:0] port_pin_o,
  output logic [`BSW_PORT_W-1:0] port_pin_oe,
  output logic irq
);
  import bsw_pkg::*;

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam logic [`BSW_CNT_W-1:0] POWERUP_TIMER_LAST = `BSW_CNT_W'(POWERUP_CYCLES - 1);
  localparam logic [`BSW_CNT_W-1:0] BOR_LAST = `BSW_CNT_W'(BROWNOUT_MIN_CYCLES);
  localparam logic [`BSW_CNT_W-1:0] OST_LAST = `BSW_CNT_W'(`BSW_OST_TOSC - 1);
  localparam seq_s SEQ_RST = '{
    st: ST_HOLD,
    cnt: '0,
    bor_cnt: '0,
    ctrl: `BSW_CTRL_RST,
    powerdown_flag: 1'b1,
    timeout_flag: 1'b1,
    int_status: '0,
    int_mask: '0,
    port_o: '0,
    port_oe: '0,
    pf_addr: '0,
    pf_req: 1'b0,
    wdt_clr: 1'b0,
    wake: 1'b0,
    vec: 1'b0,
    gie_wake: 1'b0,
    prdata: '0
  };

  // Crystal and resonator modes need start-up time; RC starts at once
  function automatic logic needs_ost(input logic [`BSW_CTRL_W-1:0] ctrl);
    osc_mode_e mode;
    mode = osc_mode_e'(ctrl[`BSW_CTRL_OSC_HI:`BSW_CTRL_OSC_LO]);
    return mode != OSC_RC;
  endfunction

  // Wrapping count step, shared by all timers
  function automatic logic [`BSW_CNT_W-1:0] step(input logic [`BSW_CNT_W-1:0] v);
    return v + `BSW_CNT_W'(1);
  endfunction

  seq_s q;
  seq_s d;
  logic acc;
  logic setup;
  logic mapped;
  logic bor_trip;
  logic irq_wake;
  logic wdt_wake;
  logic [`BSW_IRQ_W-1:0] ev;
  logic [`BSW_IRQ_W-1:0] w1c;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // No wait states; read data latched in the setup cycle
  always_comb begin
    setup = psel && !penable;
    acc = psel && penable;
    mapped = (paddr == `BSW_OFF_CTRL) || (paddr == `BSW_OFF_STATUS) ||
             (paddr == `BSW_OFF_INT_STATUS) || (paddr == `BSW_OFF_INT_MASK);
    w1c = '0;
    if (acc && pwrite && paddr == `BSW_OFF_INT_STATUS) begin
      w1c = pwdata[`BSW_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    d.pf_req = 1'b0;
    d.wdt_clr = 1'b0;
    d.wake = 1'b0;
    d.vec = 1'b0;
    ev = '0;

    // Dip filter: only a low level outlasting the minimum trips
    if (q.ctrl[`BSW_CTRL_BOR_BIT] && supply_low) begin
      if (q.bor_cnt != BOR_LAST) begin
        d.bor_cnt = step(q.bor_cnt);
      end
    end else begin
      d.bor_cnt = '0;
    end
    bor_trip = q.ctrl[`BSW_CTRL_BOR_BIT] && supply_low && (q.bor_cnt == BOR_LAST);

    // Global enable plays no part in waking
    irq_wake = |(irq_flag & irq_enable);
    wdt_wake = wdt_timeout && q.ctrl[`BSW_CTRL_WDT_BIT];

    unique case (q.st)
      ST_HOLD: begin
        // Raw supply level gates release, filtered or not
        if (!supply_low) begin
          d.cnt = '0;
          d.st = q.ctrl[`BSW_CTRL_POWERUP_TIMER_DIS_BIT] ? ST_RUN : ST_POWERUP_TIMER;
        end
      end
      ST_POWERUP_TIMER: begin
        if (supply_low) begin
          d.st = ST_HOLD;
          d.cnt = '0;
        end else if (q.cnt == POWERUP_TIMER_LAST) begin
          d.st = ST_RUN;
        end else begin
          d.cnt = step(q.cnt);
        end
      end
      ST_RUN: begin
        if (wdt_wake) begin
          // Internal reset only; pad enable stays low
          d.st = ST_HOLD;
          d.timeout_flag = 1'b0;
          ev[`BSW_EV_WDT_BIT] = 1'b1;
        end else if (sleep_exec) begin
          d.st = ST_SLEEP;
          d.powerdown_flag = 1'b0;
          d.timeout_flag = 1'b1;
          d.wdt_clr = 1'b1;
          d.pf_req = 1'b1;
          d.pf_addr = pc + `BSW_PC_W'(1);
        end
      end
      ST_SLEEP: begin
        // A source already pending wakes one cycle after entry
        if (wdt_wake || irq_wake) begin
          d.wdt_clr = 1'b1;
          d.timeout_flag = wdt_wake ? 1'b0 : q.timeout_flag;
          d.gie_wake = irq_wake && global_irq_enable;
          d.cnt = '0;
          d.st = needs_ost(q.ctrl) ? ST_OST : ST_RESUME;
        end
      end
      ST_OST: begin
        if (q.cnt == OST_LAST) begin
          d.st = ST_RESUME;
        end else begin
          d.cnt = step(q.cnt);
        end
      end
      ST_RESUME: begin
        // Continuation, not reset
        d.wake = 1'b1;
        ev[`BSW_EV_WAKE_BIT] = 1'b1;
        d.st = q.gie_wake ? ST_VEC : ST_RUN;
      end
      ST_VEC: begin
        // One instruction retires before the branch; a no-op there is harmless
        if (instr_retire) begin
          d.vec = 1'b1;
          d.gie_wake = 1'b0;
          d.st = ST_RUN;
        end
      end
    endcase

    // Pin and brown-out reset override the state transition chosen above
    if (!external_reset_pin_n || bor_trip) begin
      if (q.st == ST_SLEEP) begin
        d.wdt_clr = 1'b1;
      end
      d.st = ST_HOLD;
      d.cnt = '0;
      d.gie_wake = 1'b0;
      ev[`BSW_EV_BOR_BIT] = bor_trip;
    end

    // Pads follow the core except in sleep and during oscillator start-up
    if (q.st != ST_SLEEP && q.st != ST_OST) begin
      d.port_o = port_out;
      d.port_oe = port_dir_oe;
    end

    // Set wins over a same-cycle clear
    d.int_status = (q.int_status & ~w1c) | ev;

    // Register writes
    if (acc && pwrite) begin
      if (paddr == `BSW_OFF_CTRL) begin
        d.ctrl = pwdata[`BSW_CTRL_W-1:0];
      end
      if (paddr == `BSW_OFF_INT_MASK) begin
        d.int_mask = pwdata[`BSW_IRQ_W-1:0];
      end
    end

    // Read data
    if (setup) begin
      d.prdata = '0;
      if (paddr == `BSW_OFF_CTRL) begin
        d.prdata[`BSW_CTRL_W-1:0] = q.ctrl;
      end
      if (paddr == `BSW_OFF_STATUS) begin
        d.prdata[0] = q.powerdown_flag;
        d.prdata[1] = q.timeout_flag;
        d.prdata[2] = core_reset;
        d.prdata[3] = (q.st == ST_SLEEP);
        d.prdata[6:4] = q.st;
      end
      if (paddr == `BSW_OFF_INT_STATUS) begin
        d.prdata[`BSW_IRQ_W-1:0] = q.int_status;
      end
      if (paddr == `BSW_OFF_INT_MASK) begin
        d.prdata[`BSW_IRQ_W-1:0] = q.int_mask;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= SEQ_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Decodes of registered state or constant ties, except pready and pslverr, decoded from the bus
  assign core_reset = (q.st == ST_HOLD) || (q.st == ST_POWERUP_TIMER);
  assign core_run = (q.st == ST_RUN) || (q.st == ST_VEC);
  assign osc_drive_en = (q.st != ST_SLEEP);
  assign external_reset_pin_o = 1'b0;
  assign external_reset_pin_oe = 1'b0;
  assign wdt_clear = q.wdt_clr;
  assign prefetch_req = q.pf_req;
  assign prefetch_addr = q.pf_addr;
  assign wake_pulse = q.wake;
  assign vector_branch = q.vec;
  assign vector_addr = `BSW_VECTOR_ADDR;
  assign powerdown_flag = q.powerdown_flag;
  assign timeout_flag = q.timeout_flag;
  assign port_pin_o = q.port_o;
  assign port_pin_oe = q.port_oe;
  assign irq = |(q.int_status & q.int_mask);
  assign prdata = q.prdata;
  assign pready = acc;
  assign pslverr = acc && !mapped;

endmodule

// File: verilog/bsw_params.svh
`ifndef BSW_PARAMS_SVH
`define BSW_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define BSW_CLK_MHZ 125
`define BSW_POWERUP_MS 72
`define BSW_BROWNOUT_MIN_US 100
`define BSW_OST_TOSC 1024
`define BSW_CNT_W 24

// ----------------------------------------------------------------------
// Widths and fixed values
// ----------------------------------------------------------------------
`define BSW_PORT_W 8
`define BSW_PC_W 13
`define BSW_IRQ_W 3
`define BSW_VECTOR_ADDR 13'h0004

// ----------------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------------
`define BSW_OFF_CTRL 12'h000
`define BSW_OFF_STATUS 12'h004
`define BSW_OFF_INT_STATUS 12'h008
`define BSW_OFF_INT_MASK 12'h00C
`define BSW_CTRL_BOR_BIT 0
`define BSW_CTRL_POWERUP_TIMER_DIS_BIT 1
`define BSW_CTRL_WDT_BIT 2
`define BSW_CTRL_OSC_LO 3
`define BSW_CTRL_OSC_HI 4
`define BSW_CTRL_W 5
`define BSW_CTRL_RST 5'h09
`define BSW_EV_BOR_BIT 0
`define BSW_EV_WDT_BIT 1
`define BSW_EV_WAKE_BIT 2

`endif

// File: verilog/bsw_pkg.sv
`include "bsw_params.svh"

package bsw_pkg;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_POWERUP_TIMER,
    ST_RUN,
    ST_SLEEP,
    ST_OST,
    ST_RESUME,
    ST_VEC
  } seq_state_e;

  typedef enum logic [1:0] {
    OSC_LP,
    OSC_XT,
    OSC_HS,
    OSC_RC
  } osc_mode_e;

  typedef struct packed {
    seq_state_e st;
    logic [`BSW_CNT_W-1:0] cnt;
    logic [`BSW_CNT_W-1:0] bor_cnt;
    logic [`BSW_CTRL_W-1:0] ctrl;
    logic powerdown_flag;
    logic timeout_flag;
    logic [`BSW_IRQ_W-1:0] int_status;
    logic [`BSW_IRQ_W-1:0] int_mask;
    logic [`BSW_PORT_W-1:0] port_o;
    logic [`BSW_PORT_W-1:0] port_oe;
    logic [`BSW_PC_W-1:0] pf_addr;
    logic pf_req;
    logic wdt_clr;
    logic wake;
    logic vec;
    logic gie_wake;
    logic [31:0] prdata;
  } seq_s;

endpackage

// File: test/bsw_asserts.sv
`timescale 1ns/100ps
`include "bsw_params.svh"
module bsw_asserts #(
  parameter int unsigned POWERUP_CYCLES = 20,
  parameter int unsigned BROWNOUT_MIN_CYCLES = 5
) (
  input wire logic ref_clk, srst, supply_low, external_reset_pin_n, instr_retire,
  input wire logic wdt_timeout, wdt_clear, core_reset, core_run, osc_drive_en,
  input wire logic external_reset_pin_oe, prefetch_req, wake_pulse, vector_branch,
  input wire logic powerdown_flag, timeout_flag,
  input wire logic [`BSW_PC_W-1:0] pc, prefetch_addr, vector_addr,
  input wire logic [`BSW_IRQ_W-1:0] irq_flag, irq_enable,
  input wire logic [`BSW_PORT_W-1:0] port_pin_o, port_pin_oe
);
  // ------------------------------------------------------------
  // Sequencer checks
  // ------------------------------------------------------------
  int unsigned ok_q;
  int unsigned low_q;
  logic pend;
  assign pend = |(irq_flag & irq_enable);
  // Run lengths; cleared in reset so no unknown leaks in
  always_ff @(posedge ref_clk) begin
    ok_q <= (!srst && core_reset && !supply_low && external_reset_pin_n) ? ok_q + 1 : 0;
    low_q <= (!srst && supply_low) ? low_q + 1 : 0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  pin_idle_a: assert property (!external_reset_pin_oe)
    else $error("reset pin driven");
  sleep_entry_a: assert property ($fell(osc_drive_en) |->
    !powerdown_flag && timeout_flag && wdt_clear && prefetch_req)
    else $error("bad sleep entry");
  prefetch_next_a: assert property (prefetch_req |-> prefetch_addr == $past(pc) + 13'h1)
    else $error("bad prefetch address");
  ports_frozen_a: assert property (!osc_drive_en |=> $stable(port_pin_o) && $stable(port_pin_oe))
    else $error("ports moved in sleep");
  vector_target_a: assert property (vector_branch |->
    vector_addr == 13'h0004 && $past(instr_retire))
    else $error("bad vector branch");
  wake_wdt_clr_a: assert property ($rose(osc_drive_en) |-> wdt_clear)
    else $error("no watchdog clear on wake");
  irq_wakes_a: assert property (!osc_drive_en && pend |=> osc_drive_en)
    else $error("no wake on irq");
  stays_asleep_a: assert property (!osc_drive_en && !pend && !wdt_timeout &&
    external_reset_pin_n && !supply_low |=> !osc_drive_en)
    else $error("spurious wake");
  powerup_delay_a: assert property ($fell(core_reset) |-> ok_q >= POWERUP_CYCLES)
    else $error("power-up delay short");
  short_dip_a: assert property (!core_reset && supply_low && low_q + 2 < BROWNOUT_MIN_CYCLES &&
    external_reset_pin_n && !wdt_timeout |=> !core_reset)
    else $error("reset on short dip");
  wake_resumes_a: assert property (wake_pulse |-> core_run && !core_reset)
    else $error("wake did not resume");
  cover property (vector_branch);
  cover property ($fell(osc_drive_en) && pend);
  cover property ($rose(core_reset) && supply_low);
endmodule
bind brownout_sleep_wake_control bsw_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES),
  .BROWNOUT_MIN_CYCLES(BROWNOUT_MIN_CYCLES)) u_bsw_asserts (.*);

// File: test/bsw_env.sv
`timescale 1ns/100ps
`include "bsw_params.svh"
module bsw_env (
  input wire logic ref_clk,
  output logic supply_low,
  output logic pin_n,
  output logic wdt_timeout,
  output logic [`BSW_IRQ_W-1:0] irq_flag
);
  // ------------------------------------------------------------
  // Supply monitor, reset pin and interrupt sources
  // ------------------------------------------------------------
  initial begin
    supply_low = 1'b0;
    pin_n = 1'b1;
    wdt_timeout = 1'b0;
    irq_flag = '0;
  end
  // Callers enter on a rising edge, so every change lands just after it
  task automatic dip(input int k);
    supply_low <= 1'b1;
    repeat (k) @(posedge ref_clk);
    supply_low <= 1'b0;
  endtask
  task automatic pin_reset(input int k);
    pin_n <= 1'b0;
    repeat (k) @(posedge ref_clk);
    pin_n <= 1'b1;
  endtask
  task automatic wd_pulse;
    wdt_timeout <= 1'b1;
    @(posedge ref_clk);
    wdt_timeout <= 1'b0;
  endtask
  // Flags stay up until the core side clears them
  task automatic raise(input logic [`BSW_IRQ_W-1:0] v);
    irq_flag <= v;
  endtask
endmodule

// File: test/brownout_sleep_wake_control_tb.sv
`timescale 1ns/100ps
`include "bsw_params.svh"
module brownout_sleep_wake_control_tb;
  // ------------------------------------------------------------
  // Bench
  // ------------------------------------------------------------
  localparam int unsigned PU = 20;
  localparam int unsigned BM = 5;
  logic ref_clk = 0, srst, psel, penable, pwrite, err;
  logic sleep_exec, instr_retire, global_irq_enable, env_pin_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, prdata, seed = 32'h0000_ee12;
  logic [12:0] pc, prefetch_addr, vector_addr, pq[$];
  logic [2:0] irq_enable, irq_flag, watch;
  logic [7:0] port_out, port_dir_oe, port_pin_o, port_pin_oe;
  logic pready, pslverr, supply_low, external_reset_pin_n, external_reset_pin_o;
  logic external_reset_pin_oe, wdt_timeout, wdt_clear, core_reset, core_run, osc_drive_en;
  logic prefetch_req, wake_pulse, vector_branch, powerdown_flag, timeout_flag, irq;
  int n_mismatch = 0, n_compared = 0, cyc = 0, n;
  assign external_reset_pin_n = env_pin_n & ~(external_reset_pin_oe & ~external_reset_pin_o);
  assign watch = {~core_reset, vector_branch, wake_pulse};
  brownout_sleep_wake_control #(.POWERUP_CYCLES(PU), .BROWNOUT_MIN_CYCLES(BM))
    u_brownout_sleep_wake_control (.*);
  bsw_env u_bsw_env (.ref_clk(ref_clk), .supply_low(supply_low), .pin_n(env_pin_n),
    .wdt_timeout(wdt_timeout), .irq_flag(irq_flag));
  initial forever #4 ref_clk = ~ref_clk;
  // Idle levels; every input is driven by the stimulus later on
  initial begin
    srst <= 1'b1;
    {psel, penable, pwrite, sleep_exec, instr_retire, global_irq_enable} <= '0;
    paddr <= '0;
    pwdata <= '0;
    pc <= '0;
    irq_enable <= '0;
    port_out <= '0;
    port_dir_oe <= '0;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Random port traffic, plus the hang guard
  always @(posedge ref_clk) begin
    seed <= xs(seed);
    port_out <= seed[7:0];
    port_dir_oe <= seed[15:8];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait on one watched signal; n keeps the cycle count
  task automatic wait_hi(input int k, input int lim);
    n = 0;
    while (watch[k] !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    check(n < lim, 1);
  endtask
  task automatic sleep_go;
    pq.push_back(seed[12:0] + 13'h1);
    pc <= seed[12:0];
    sleep_exec <= 1'b1;
    @(posedge ref_clk);
    sleep_exec <= 1'b0;
    // Look mid-cycle: a pending source may leave sleep on the next edge
    @(negedge ref_clk);
    check({osc_drive_en, powerdown_flag, timeout_flag}, 3'h1);
    check(prefetch_addr, pq.pop_front());
    @(posedge ref_clk);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence: registers, brown-out, sleep and wake paths
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    wait_hi(2, 500);
    check(n >= PU && n < PU + 4, 1);
    apb(0, 12'h000, 0);
    check(rd, 32'h0000_0009);
    apb(0, 12'h004, 0);
    check(rd, 32'h0000_0023);
    apb(0, 12'h010, 0);
    check({err, rd[30:0]}, 32'h8000_0000);
    apb(1, 12'h00c, 32'h0000_0001);
    u_bsw_env.dip(BM - 2);
    repeat (2) @(posedge ref_clk);
    check(core_reset, 0);
    u_bsw_env.dip(BM + 3);
    repeat (2) @(posedge ref_clk);
    check({core_reset, irq}, 2'h3);
    apb(1, 12'h008, 32'h0000_0001);
    @(posedge ref_clk);
    check(irq, 0);
    u_bsw_env.dip(1);
    wait_hi(2, 500);
    check(n >= PU && n < PU + 4, 1);
    apb(1, 12'h000, 32'h0000_0018);
    u_bsw_env.dip(BM + 3);
    repeat (2) @(posedge ref_clk);
    check(core_reset, 0);
    apb(1, 12'h000, 32'h0000_001d);
    $display("brownout test done");
    for (int m = 0; m < 6; m++) begin
      global_irq_enable <= m[0];
      sleep_go;
      u_bsw_env.raise(3'h1 << (m / 2));
      repeat (3) @(posedge ref_clk);
      check(osc_drive_en, 0);
      irq_enable <= 3'h1 << (m / 2);
      wait_hi(0, 8);
      if (m[0]) begin
        instr_retire <= 1'b1;
        @(posedge ref_clk);
        instr_retire <= 1'b0;
        wait_hi(1, 8);
        check(vector_addr, 32'h0000_0004);
      end
      u_bsw_env.raise(3'h0);
      irq_enable <= 3'h0;
      repeat (2) @(posedge ref_clk);
      check(core_run, 1);
    end
    u_bsw_env.raise(3'h4);
    irq_enable <= 3'h4;
    global_irq_enable <= 1'b0;
    sleep_go;
    wait_hi(0, 4);
    u_bsw_env.raise(3'h0);
    irq_enable <= 3'h0;
    repeat (2) @(posedge ref_clk);
    sleep_go;
    u_bsw_env.wd_pulse;
    wait_hi(0, 8);
    check({core_reset, timeout_flag}, 0);
    repeat (2) @(posedge ref_clk);
    u_bsw_env.wd_pulse;
    repeat (2) @(posedge ref_clk);
    check({core_reset, external_reset_pin_oe}, 2'h2);
    wait_hi(2, 500);
    $display("sleep test done");
    apb(1, 12'h000, 32'h0000_000d);
    sleep_go;
    u_bsw_env.raise(3'h2);
    irq_enable <= 3'h2;
    wait_hi(0, 1100);
    check(n >= 1024, 1);
    u_bsw_env.raise(3'h0);
    irq_enable <= 3'h0;
    repeat (2) @(posedge ref_clk);
    sleep_go;
    u_bsw_env.pin_reset(3);
    check(core_reset, 1);
    wait_hi(2, 500);
    $display("wake test done");
    report_and_stop;
  end
endmodule
